// file: rtl/stm_params.svh
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH

// register offsets (byte addresses)
`define STM_REG_CTRL      8'h00
`define STM_REG_USER_SEC  8'h04
`define STM_REG_PPS_CORR  8'h08
`define STM_REG_ETH_CORR  8'h0c
`define STM_REG_LINE_NOM  8'h10
`define STM_REG_STATUS    8'h14
`define STM_REG_PHASE     8'h20
`define STM_REG_DEVIATION 8'h24
`define STM_REG_LOWPASS   8'h28
`define STM_REG_CONST_TE  8'h2c
`define STM_REG_SYNC_OWD  8'h30
`define STM_REG_DREQ_OWD  8'h34
`define STM_REG_FWD_TE    8'h38
`define STM_REG_REV_TE    8'h3c
`define STM_REG_PKT_TE    8'h40
`define STM_REG_TIE       8'h44
`define STM_REG_ELAPSED   8'h48

// control register fields
`define STM_CTRL_START    0
`define STM_CTRL_STOP     1
`define STM_CTRL_PTP_EN   2
`define STM_CTRL_SLAVE    3
`define STM_CTRL_TWO_STEP 4
`define STM_CTRL_REL_MODE 5
`define STM_CTRL_PSEL_LO  6
`define STM_CTRL_PSEL_HI  7

// reset values
`define STM_RST_USER_SEC  32'h0000_0e10
`define STM_RST_LINE_NOM  32'h0000_0008

// timing
`define STM_CLK_NS        5
`define STM_SEC_NS        1000000000
`define STM_WRAP_NS       48'h0000_3b9a_ca00
`define STM_HALF_WRAP_NS  48'h0000_1dcd_6500
`define STM_PERIOD_SHORT  32'h0000_0064
`define STM_PERIOD_LONG   32'h0000_03e8
`define STM_LPF_SHIFT     1

`endif

// file: rtl/stm_pkg.sv
package stm_pkg;
    typedef struct packed {
        logic        valid;
        logic [47:0] stamp;
    } stm_msg_type;

    typedef struct packed {
        logic [31:0] phase;
        logic [31:0] lowpass;
        logic [31:0] packet_te;
    } stm_export_type;

    typedef enum logic [1:0] {
        STM_P_100S,
        STM_P_1000S,
        STM_P_USER,
        STM_P_USER_ALT
    } stm_period_type;

    typedef enum {
        STM_IDLE,
        STM_WAIT_FUP,
        STM_SEND_DREQ,
        STM_WAIT_TX,
        STM_WAIT_RESP
    } stm_ptp_state_type;
endpackage

// file: rtl/stm_sync_te.sv
// Function
// - derive phase error, deviation and filtered time error from two pulse inputs
// - phase error positive when pulse under test leads the reference
// - filtered time error is phase error through a 0.1 Hz low-pass filter
// - reported phase error is raw offset plus pulse cable correction in ns
// - constant time error uses corrected phase error, not raw offset
// - delay and packet time error only with PTP enabled and slave mode
// - capture local stamp T2 when each Sync arrives; the code takes it only for a Sync that arrives in STM_IDLE
// - T1 in Sync for one-step, in Follow_Up for two-step
// - after Sync, send Delay_Req and capture its departure stamp T3
// - Sync delay from T1,T2; Delay_Req delay from T3,T4
// - forward time error is minus Sync delay plus cable correction
// - reverse time error is Delay_Req delay minus cable correction
// - packet time error is half of forward plus reverse
// - one Ethernet cable correction serves both directions
// - sample line clock phase against reference at fixed intervals as TIME_INTERVAL_ERROR
// - relative pulse mode wraps delays and errors into plus/minus 500 ms
// - run stops after 100 s, 1000 s or a user period
// - user period emits pulse and time error results every second
// - deviation is period deviation of successive pulses under test
// - constant time error is mean of corrected phase error
//
// Our own choices: strobed register access and the register offsets.
`include "stm_params.svh"
module stm_sync_te #(
    parameter int unsigned CYCLES_PER_SEC = `STM_SEC_NS / `STM_CLK_NS,
    parameter int unsigned LPF_SHIFT      = `STM_LPF_SHIFT
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic [7:0]              addr_in,
    input  wire logic [31:0]             wdata_in,
    input  wire logic                    wr_in,
    input  wire logic                    rd_in,
    output logic [31:0]                  rdata_out,
    input  wire logic                    pps_ref_in,
    input  wire logic                    pps_dut_in,
    input  wire logic                    line_clk_in,
    input  wire stm_pkg::stm_msg_type    sync_rx_in,
    input  wire stm_pkg::stm_msg_type    follow_up_rx_in,
    input  wire stm_pkg::stm_msg_type    delay_resp_rx_in,
    input  wire logic                    dreq_sent_in,
    output logic                         dreq_send_out,
    output logic                         running_out,
    output logic                         export_valid_out,
    output stm_pkg::stm_export_type      export_data_out
);
    import stm_pkg::*;

    if (CYCLES_PER_SEC < 2 || LPF_SHIFT > 16) begin : g_check
        $error("stm_sync_te: unsupported parameter values");
    end

    logic [47:0]        tcnt, ref_t, dut_t, t1, t2, t3, line_first, line_last, div_dvd, div_quo;
    logic [31:0]        user_sec, pps_corr, eth_corr, line_nom, period, cyc_cnt, sec_cnt;
    logic [31:0]        pe_cnt, line_edges, div_dsr;
    logic [32:0]        div_rem, div_try;
    logic [5:0]         div_cnt;
    logic [2:0]         ref_s, dut_s, line_s;
    logic               ptp_en, slave, two_step, rel_mode, running, sec_tick, start_wr, stop_wr, pair, ptp_go;
    logic               ref_edge, dut_edge, line_edge, got_ref, got_dut, dut_seen, line_seen, div_busy, div_neg;
    logic signed [47:0] next_phase, pe_sum, next_sowd, next_rowd, next_fwd, next_rev, next_pte;
    logic signed [31:0] phase, deviation, lowpass, const_te, sync_owd, dreq_owd, fwd_te, rev_te, pkt_te, time_interval_error;
    stm_period_type     psel;
    stm_ptp_state_type  state;

    // relative pulse mode wrap into the +/-500 ms window
    function automatic logic signed [47:0] wrap(input logic signed [47:0] v, input logic en);
        logic [47:0] mag;
        logic [47:0] r;
        mag = v[47] ? 48'(-v) : 48'(v);
        r   = mag % `STM_WRAP_NS;
        if (r > `STM_HALF_WRAP_NS) begin
            r = r - `STM_WRAP_NS;
        end
        if (v[47]) begin
            r = 48'(-r);
        end
        wrap = en ? $signed(r) : v;
    endfunction

    assign start_wr = wr_in && addr_in == `STM_REG_CTRL && wdata_in[`STM_CTRL_START];
    assign stop_wr  = wr_in && addr_in == `STM_REG_CTRL && wdata_in[`STM_CTRL_STOP];
    assign sec_tick = running && cyc_cnt == CYCLES_PER_SEC - 1;
    assign ref_edge  = ref_s[1] & ~ref_s[2];
    assign dut_edge  = dut_s[1] & ~dut_s[2];
    assign line_edge = line_s[1] & ~line_s[2];
    assign pair      = got_ref && got_dut;
    assign ptp_go    = running && ptp_en && slave;

    always_comb begin
        case (psel)
            STM_P_100S:  period = `STM_PERIOD_SHORT;
            STM_P_1000S: period = `STM_PERIOD_LONG;
            default:     period = user_sec;
        endcase
    end

    // free-running ns counter shared by every local stamp; T1 and T4 arrive in messages
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tcnt <= '0;
        end else begin
            tcnt <= tcnt + 48'(`STM_CLK_NS);
        end
    end

    // configuration registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            user_sec <= `STM_RST_USER_SEC;
            pps_corr <= '0;
            eth_corr <= '0;
            line_nom <= `STM_RST_LINE_NOM;
            ptp_en   <= 1'b0;
            slave    <= 1'b0;
            two_step <= 1'b0;
            rel_mode <= 1'b0;
            psel     <= STM_P_100S;
        end else if (wr_in) begin
            case (addr_in)
                `STM_REG_CTRL: begin
                    ptp_en   <= wdata_in[`STM_CTRL_PTP_EN];
                    slave    <= wdata_in[`STM_CTRL_SLAVE];
                    two_step <= wdata_in[`STM_CTRL_TWO_STEP];
                    rel_mode <= wdata_in[`STM_CTRL_REL_MODE];
                    psel     <= stm_period_type'(wdata_in[`STM_CTRL_PSEL_HI:`STM_CTRL_PSEL_LO]);
                end
                `STM_REG_USER_SEC: user_sec <= wdata_in;
                `STM_REG_PPS_CORR: pps_corr <= wdata_in;
                `STM_REG_ETH_CORR: eth_corr <= wdata_in;
                `STM_REG_LINE_NOM: line_nom <= wdata_in;
                default: ;
            endcase
        end
    end

    // run control and seconds timebase
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            running <= 1'b0;
            cyc_cnt <= '0;
            sec_cnt <= '0;
        end else if (start_wr) begin
            running <= 1'b1;
            cyc_cnt <= '0;
            sec_cnt <= '0;
        end else if (stop_wr) begin
            running <= 1'b0;
        end else if (sec_tick) begin
            cyc_cnt <= '0;
            sec_cnt <= sec_cnt + 32'h1;
            if (sec_cnt + 32'h1 >= period) begin
                running <= 1'b0;
            end
        end else if (running) begin
            cyc_cnt <= cyc_cnt + 32'h1;
        end
    end

    // pin synchronisers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ref_s  <= '0;
            dut_s  <= '0;
            line_s <= '0;
        end else begin
            ref_s  <= {ref_s[1:0], pps_ref_in};
            dut_s  <= {dut_s[1:0], pps_dut_in};
            line_s <= {line_s[1:0], line_clk_in};
        end
    end

    // pulse comparison: ref minus dut, positive when dut leads
    assign next_phase = $signed(ref_t - dut_t) + 48'($signed(pps_corr));

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ref_t     <= '0;
            dut_t     <= '0;
            got_ref   <= 1'b0;
            got_dut   <= 1'b0;
            dut_seen  <= 1'b0;
            phase     <= '0;
            deviation <= '0;
            lowpass   <= '0;
            pe_sum    <= '0;
            pe_cnt    <= '0;
        end else begin
            if (ref_edge) begin
                ref_t <= tcnt;
            end
            got_ref <= ref_edge || (got_ref && !pair);
            got_dut <= dut_edge || (got_dut && !pair);
            if (dut_edge) begin
                dut_t    <= tcnt;
                dut_seen <= 1'b1;
                if (dut_seen && running) begin
                    deviation <= 32'($signed(tcnt - dut_t) - 48'(`STM_SEC_NS));
                end
            end
            if (start_wr) begin
                pe_sum <= '0;
                pe_cnt <= '0;
            end else if (pair && running) begin
                phase   <= 32'(next_phase);
                lowpass <= lowpass + ((32'(next_phase) - lowpass) >>> LPF_SHIFT);
                pe_sum  <= pe_sum + next_phase;
                pe_cnt  <= pe_cnt + 32'h1;
            end
        end
    end

    // mean of corrected phase error by a serial divider, once per second
    assign div_try = {div_rem[31:0], div_dvd[47]};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div_busy <= 1'b0;
            div_cnt  <= '0;
            div_dvd  <= '0;
            div_dsr  <= '0;
            div_rem  <= '0;
            div_quo  <= '0;
            div_neg  <= 1'b0;
            const_te <= '0;
        end else if (!div_busy) begin
            if (sec_tick && pe_cnt != 0) begin
                div_busy <= 1'b1;
                div_cnt  <= 6'd48;
                div_dvd  <= pe_sum[47] ? 48'(-pe_sum) : 48'(pe_sum);
                div_neg  <= pe_sum[47];
                div_dsr  <= pe_cnt;
                div_rem  <= '0;
                div_quo  <= '0;
            end
        end else if (div_cnt == 0) begin
            div_busy <= 1'b0;
            const_te <= div_neg ? 32'(-div_quo) : div_quo[31:0];
        end else begin
            div_cnt <= div_cnt - 6'd1;
            div_dvd <= {div_dvd[46:0], 1'b0};
            if (div_try >= {1'b0, div_dsr}) begin
                div_rem <= div_try - {1'b0, div_dsr};
                div_quo <= {div_quo[46:0], 1'b1};
            end else begin
                div_rem <= div_try;
                div_quo <= {div_quo[46:0], 1'b0};
            end
        end
    end

    // packet delay and time error arithmetic
    always_comb begin
        next_sowd = wrap($signed(t2 - t1), rel_mode);
        next_rowd = wrap($signed(delay_resp_rx_in.stamp - t3), rel_mode);
        next_fwd  = wrap(-$signed(t2 - t1) + 48'($signed(eth_corr)), rel_mode);
        next_rev  = wrap($signed(delay_resp_rx_in.stamp - t3) - 48'($signed(eth_corr)), rel_mode);
        next_pte  = wrap((-$signed(t2 - t1) + $signed(delay_resp_rx_in.stamp - t3)) >>> 1, rel_mode);
    end

    // slave-side timing message exchange
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state         <= STM_IDLE;
            t1            <= '0;
            t2            <= '0;
            t3            <= '0;
            dreq_send_out <= 1'b0;
            sync_owd      <= '0;
            dreq_owd      <= '0;
            fwd_te        <= '0;
            rev_te        <= '0;
            pkt_te        <= '0;
        end else begin
            dreq_send_out <= 1'b0;
            if (!ptp_go) begin
                state <= STM_IDLE;
            end else begin
                case (state)
                    STM_IDLE: begin
                        if (sync_rx_in.valid) begin
                            t2 <= tcnt;
                            t1 <= sync_rx_in.stamp;
                            state <= two_step ? STM_WAIT_FUP : STM_SEND_DREQ;
                        end
                    end
                    STM_WAIT_FUP: begin
                        if (follow_up_rx_in.valid) begin
                            t1    <= follow_up_rx_in.stamp;
                            state <= STM_SEND_DREQ;
                        end
                    end
                    STM_SEND_DREQ: begin
                        dreq_send_out <= 1'b1;
                        state         <= STM_WAIT_TX;
                    end
                    STM_WAIT_TX: begin
                        if (dreq_sent_in) begin
                            t3    <= tcnt;
                            state <= STM_WAIT_RESP;
                        end
                    end
                    STM_WAIT_RESP: begin
                        if (delay_resp_rx_in.valid) begin
                            sync_owd <= 32'(next_sowd);
                            dreq_owd <= 32'(next_rowd);
                            fwd_te   <= 32'(next_fwd);
                            rev_te   <= 32'(next_rev);
                            pkt_te   <= 32'(next_pte);
                            state    <= STM_IDLE;
                        end
                    end
                    default: state <= STM_IDLE;
                endcase
            end
        end
    end

    // line clock wander: elapsed time minus nominal edges, sampled each second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            line_first <= '0;
            line_last  <= '0;
            line_edges <= '0;
            line_seen  <= 1'b0;
            time_interval_error        <= '0;
        end else begin
            if (start_wr) begin
                line_seen  <= 1'b0;
                line_edges <= '0;
            end else if (line_edge && running) begin
                line_last <= tcnt;
                if (!line_seen) begin
                    line_first <= tcnt;
                    line_seen  <= 1'b1;
                end else begin
                    line_edges <= line_edges + 32'h1;
                end
            end
            if (sec_tick && line_seen) begin
                time_interval_error <= 32'($signed(line_last - line_first) - $signed(48'(line_edges * line_nom)));
            end
        end
    end

    // outputs and per-second export
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            running_out      <= 1'b0;
            export_valid_out <= 1'b0;
            export_data_out  <= '0;
        end else begin
            running_out      <= running;
            export_valid_out <= sec_tick && psel[1];
            if (sec_tick && psel[1]) begin
                export_data_out <= '{phase: phase, lowpass: lowpass, packet_te: pkt_te};
            end
        end
    end

    // register read port
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            case (addr_in)
                `STM_REG_CTRL:      rdata_out <= {24'h0, psel, rel_mode, two_step, slave, ptp_en, 2'h0};
                `STM_REG_USER_SEC:  rdata_out <= user_sec;
                `STM_REG_PPS_CORR:  rdata_out <= pps_corr;
                `STM_REG_ETH_CORR:  rdata_out <= eth_corr;
                `STM_REG_LINE_NOM:  rdata_out <= line_nom;
                `STM_REG_STATUS:    rdata_out <= {28'h0, div_busy, line_seen, dut_seen, running};
                `STM_REG_PHASE:     rdata_out <= phase;
                `STM_REG_DEVIATION: rdata_out <= deviation;
                `STM_REG_LOWPASS:   rdata_out <= lowpass;
                `STM_REG_CONST_TE:  rdata_out <= const_te;
                `STM_REG_SYNC_OWD:  rdata_out <= sync_owd;
                `STM_REG_DREQ_OWD:  rdata_out <= dreq_owd;
                `STM_REG_FWD_TE:    rdata_out <= fwd_te;
                `STM_REG_REV_TE:    rdata_out <= rev_te;
                `STM_REG_PKT_TE:    rdata_out <= pkt_te;
                `STM_REG_TIE:       rdata_out <= time_interval_error;
                `STM_REG_ELAPSED:   rdata_out <= sec_cnt;
                default:            rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end
endmodule

// file: tb/stm_sync_te_asserts.sv
`include "stm_params.svh"
module stm_sync_te_asserts (
    input wire logic                    clk_in,
    input wire logic                    rst_in,
    input wire logic [7:0]              addr_in,
    input wire logic [31:0]             wdata_in,
    input wire logic                    wr_in,
    input wire logic                    rd_in,
    input wire logic [31:0]             rdata_out,
    input wire stm_pkg::stm_msg_type    sync_rx_in,
    input wire stm_pkg::stm_msg_type    follow_up_rx_in,
    input wire logic                    dreq_send_out,
    input wire logic                    running_out,
    input wire logic                    export_valid_out,
    input wire stm_pkg::stm_export_type export_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import stm_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    sequence start_wr;
        wr_in && addr_in == `STM_REG_CTRL && wdata_in[0] && !wdata_in[1];
    endsequence
    sequence stop_wr;
        wr_in && addr_in == `STM_REG_CTRL && wdata_in[1] && !wdata_in[0];
    endsequence
    rd_slot_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside its slot");
    dreq_pulse_a: assert property (dreq_send_out |=> !dreq_send_out)
        else $error("delay request longer than one cycle");
    dreq_cause_a: assert property (dreq_send_out |-> $past(sync_rx_in.valid, 2) || $past(follow_up_rx_in.valid, 2))
        else $error("delay request without timing message");
    export_pulse_a: assert property (export_valid_out |=> !export_valid_out)
        else $error("export strobe longer than one cycle");
    export_hold_a: assert property (!export_valid_out |-> $stable(export_data_out))
        else $error("export data moved between strobes");
    start_run_a: assert property (start_wr |-> ##2 running_out)
        else $error("start did not raise running");
    stop_run_a: assert property (stop_wr |-> ##[1:3] !running_out)
        else $error("stop did not end the run");
    run_cause_a: assert property ($rose(running_out) |-> $past(wr_in && addr_in == `STM_REG_CTRL && wdata_in[0], 2))
        else $error("run began without start");
endmodule
bind stm_sync_te stm_sync_te_asserts chk (.*);

// file: tb/stm_ptp_master.sv
module stm_ptp_master (
    input  wire logic               clk_in,
    input  wire logic               go_in,
    input  wire logic               two_step_in,
    input  wire logic [47:0]        t1_in,
    input  wire logic [47:0]        t4_in,
    input  wire logic [3:0]         lag_in,
    input  wire logic               dreq_send_in,
    output stm_pkg::stm_msg_type    sync_out,
    output stm_pkg::stm_msg_type    follow_up_out,
    output stm_pkg::stm_msg_type    delay_resp_out,
    output logic                    dreq_sent_out,
    output logic [15:0]             gap_out,
    output logic                    busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import stm_pkg::*;
    logic [15:0] cyc = 16'h0;
    logic [15:0] t0;
    int          i;
    initial {sync_out, follow_up_out, delay_resp_out, dreq_sent_out, gap_out, busy_out} = '0;
    always @(posedge clk_in) cyc <= cyc + 16'h1;
    // released stamps show the inverse so stale values cannot pass
    always @(posedge clk_in) begin
        if (go_in) begin
            busy_out <= 1'b1;
            t0 = cyc;
            sync_out <= '{1'b1, two_step_in ? ~t1_in : t1_in};
            @(posedge clk_in);
            sync_out <= '{1'b0, ~t1_in};
            if (two_step_in) begin
                repeat (2) @(posedge clk_in);
                follow_up_out <= '{1'b1, t1_in};
                @(posedge clk_in);
                follow_up_out <= '{1'b0, ~t1_in};
            end
            for (i = 0; i < 20 && dreq_send_in !== 1'b1; i++) @(posedge clk_in);
            if (dreq_send_in === 1'b1) begin
                repeat (lag_in) @(posedge clk_in);
                dreq_sent_out <= 1'b1;
                gap_out <= cyc - t0;
                @(posedge clk_in);
                dreq_sent_out <= 1'b0;
                repeat (3) @(posedge clk_in);
                delay_resp_out <= '{1'b1, t4_in};
                @(posedge clk_in);
                delay_resp_out <= '{1'b0, ~t4_in};
            end
            repeat (2) @(posedge clk_in);
            busy_out <= 1'b0;
        end
    end
endmodule

// file: tb/test_stm_sync_te.sv
`include "stm_params.svh"
module test_stm_sync_te import stm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, pps_ref_in = 1'b0, pps_dut_in = 1'b0;
    logic line_clk_in = 1'b0, go = 1'b0, two = 1'b0, dreq_sent, dreq_send, running, exp_v, busy;
    logic [7:0] addr_in = 8'h0;
    logic [31:0] wdata_in = 32'h0, rdata_out;
    logic [47:0] t1 = 48'h0, t4 = 48'd600000;
    logic [3:0] lag = 4'h1;
    logic [15:0] gap;
    stm_msg_type sync, fup, dresp;
    stm_export_type exp_d;
    int fails = 0, checks = 0, exports = 0, dreqs = 0;
    stm_sync_te #(.CYCLES_PER_SEC(100), .LPF_SHIFT(1)) DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pps_ref_in(pps_ref_in),
        .pps_dut_in(pps_dut_in), .line_clk_in(line_clk_in), .sync_rx_in(sync), .follow_up_rx_in(fup),
        .delay_resp_rx_in(dresp), .dreq_sent_in(dreq_sent), .dreq_send_out(dreq_send), .running_out(running),
        .export_valid_out(exp_v), .export_data_out(exp_d));
    stm_ptp_master far (.clk_in(clk_in), .go_in(go), .two_step_in(two), .t1_in(t1), .t4_in(t4), .lag_in(lag),
        .dreq_send_in(dreq_send), .sync_out(sync), .follow_up_out(fup), .delay_resp_out(dresp),
        .dreq_sent_out(dreq_sent), .gap_out(gap), .busy_out(busy));
    always #2.5 clk_in = ~clk_in;
    always #20 line_clk_in = ~line_clk_in;
    always @(posedge clk_in) begin
        exports <= exports + int'(exp_v === 1'b1);
        dreqs <= dreqs + int'(dreq_send === 1'b1);
    end
    task automatic give_verdict();
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(posedge clk_in);
        d = rdata_out;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] v;
        rd(a, v);
        check(n, v, e);
    endtask
    function automatic longint wrap(input longint v, input bit rel);
        longint m;
        m = (v < 0 ? -v : v) % 1000000000;
        if (m > 500000000) m -= 1000000000;
        return rel ? (v < 0 ? -m : m) : v;
    endfunction
    task automatic fire(input logic ts, input longint t1v, input logic [3:0] lg);
        int i;
        two <= ts;
        t1 <= 48'(t1v);
        lag <= lg;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        @(posedge clk_in);
        for (i = 0; i < 80 && busy !== 1'b0; i++) @(posedge clk_in);
        check("partner idle", {31'h0, busy}, 32'h0);
    endtask
    task automatic ptp(input logic ts, input bit rel, input longint t1v, input logic [3:0] lg);
        logic [31:0] sv, dv, v;
        longint s, d;
        fire(ts, t1v, lg);
        rd(`STM_REG_SYNC_OWD, sv);
        rd(`STM_REG_DREQ_OWD, dv);
        s = longint'($signed(sv)) - (rel ? 1000000000 : 0);
        d = longint'($signed(dv));
        check("delay sum", sv + dv, 32'(600000 - t1v - 5 * longint'(gap) + (rel ? 1000000000 : 0)));
        rd(`STM_REG_FWD_TE, v);
        check("forward te", v, 32'(wrap(30 - s, rel)));
        rd(`STM_REG_REV_TE, v);
        check("reverse te", v, 32'(wrap(d - 30, rel)));
        rd(`STM_REG_PKT_TE, v);
        check("packet te", v, 32'(wrap((30 - s + d - 30) >>> 1, rel)));
    endtask
    initial begin
        repeat (25000) @(posedge clk_in);
        fails++;
        give_verdict();
    end
    initial begin
        logic [31:0] v;
        int i;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rc(`STM_REG_USER_SEC, 32'h0000_0e10, "user seconds");
        rc(`STM_REG_LINE_NOM, 32'h0000_0008, "line nominal");
        rc(8'h50, 32'h0, "unmapped");
        wr(`STM_REG_CTRL, 32'h0000_00fc);
        rc(`STM_REG_CTRL, 32'h0000_00fc, "control");
        wr(`STM_REG_PPS_CORR, 32'hffff_fff9);
        wr(`STM_REG_ETH_CORR, 32'h0000_001e);
        wr(`STM_REG_LINE_NOM, 32'h0000_0028);
        wr(`STM_REG_CTRL, 32'h0000_000d);
        // pair one: test pulse leads by 4 cycles, pair two: lags by 2
        pps_dut_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        pps_ref_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        {pps_ref_in, pps_dut_in} <= 2'b00;
        rc(`STM_REG_PHASE, 32'h0000_000d, "phase lead");
        rc(`STM_REG_LOWPASS, 32'h0000_0006, "lowpass one");
        repeat (82) @(posedge clk_in);
        pps_ref_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        pps_dut_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        {pps_ref_in, pps_dut_in} <= 2'b00;
        rc(`STM_REG_PHASE, 32'hffff_ffef, "phase lag");
        rc(`STM_REG_LOWPASS, 32'hffff_fffa, "lowpass two");
        rc(`STM_REG_DEVIATION, 32'(510 - 1000000000), "deviation");
        repeat (250) @(posedge clk_in);
        rc(`STM_REG_CONST_TE, 32'hffff_fffe, "constant te");
        rc(`STM_REG_TIE, 32'h0, "tie");
        rd(`STM_REG_STATUS, v);
        check("status", v & 32'h7, 32'h7);
        ptp(1'b0, 1'b0, 1000, 4'd1);
        wr(`STM_REG_CTRL, 32'h0000_003c);
        ptp(1'b1, 1'b1, 1200000000, 4'd6);
        wr(`STM_REG_CTRL, 32'h0000_0008);
        i = dreqs;
        fire(1'b0, 1000, 4'd1);
        check("no request", 32'(dreqs - i), 32'h0);
        wr(`STM_REG_CTRL, 32'h0000_000d);
        wr(`STM_REG_CTRL, 32'h0000_0002);
        repeat (2) @(posedge clk_in);
        check("stopped", {31'h0, running}, 32'h0);
        wr(`STM_REG_USER_SEC, 32'h0000_0003);
        i = exports;
        wr(`STM_REG_CTRL, 32'h0000_0081);
        repeat (280) @(posedge clk_in);
        check("user run", {31'h0, running}, 32'h1);
        repeat (60) @(posedge clk_in);
        check("user stop", {31'h0, running}, 32'h0);
        rc(`STM_REG_ELAPSED, 32'h3, "elapsed");
        check("exports", {31'h0, exports - i >= 2}, 32'h1);
        check("export phase", exp_d.phase, 32'hffff_ffef);
        check("export lowpass", exp_d.lowpass, 32'hffff_fffa);
        wr(`STM_REG_CTRL, 32'h0000_0001);
        repeat (9950) @(posedge clk_in);
        check("short run", {31'h0, running}, 32'h1);
        repeat (100) @(posedge clk_in);
        check("short stop", {31'h0, running}, 32'h0);
        give_verdict();
    end
endmodule
